// File: verilog/rtc_pkg.sv
// Constants, register map and field layout of the calendar clock.
// Summary of operation
// - Enabled alarm match pulls the active-low alarm interrupt output low; alarm two uses pin B when CTRL_IRQ_B is set.
// - Device is only a two-wire bus target; it never starts a transfer.
// - Register pointer advances after every data byte until STOP.
// - Date rolls over at each month end; February follows leap years.
// - Separate seconds to year counters; leap years correct through 2100.
// - Hours count in 24-hour or 12-hour AM/PM mode, chosen by software.
// - Square wave comes up at the 32 kHz rate after reset.
// - Two independent time-of-day alarms compare against the clock.
// - Square-wave pin can serve as a second interrupt output instead.
// - Time base is a crystal or external 32.768 kHz clock on input.
// - Serial port works at normal and fast bus speeds.
// - Multibyte pointer wraps from the last register back to zero.
// - START, STOP or pointer wrap copies time into a read shadow.
package rtc_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int OSC_STOP_NS = 100000;
	localparam int OSC_STOP_CYCLES =
		(OSC_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Arbitrary bus address of this target.
	localparam logic [6:0] ADDR_DEFAULT = 7'h52;
	localparam int PRESC_BITS = 15;
	localparam logic [3:0] REG_SEC = 4'h0;
	localparam logic [3:0] REG_MIN = 4'h1;
	localparam logic [3:0] REG_HOUR = 4'h2;
	localparam logic [3:0] REG_DAY = 4'h3;
	localparam logic [3:0] REG_DATE = 4'h4;
	localparam logic [3:0] REG_MON = 4'h5;
	localparam logic [3:0] REG_YEAR = 4'h6;
	localparam logic [3:0] REG_A1_SEC = 4'h7;
	localparam logic [3:0] REG_A1_MIN = 4'h8;
	localparam logic [3:0] REG_A1_HOUR = 4'h9;
	localparam logic [3:0] REG_A1_DAY = 4'hA;
	localparam logic [3:0] REG_A2_MIN = 4'hB;
	localparam logic [3:0] REG_A2_HOUR = 4'hC;
	localparam logic [3:0] REG_A2_DAY = 4'hD;
	localparam logic [3:0] REG_CTRL = 4'hE;
	localparam logic [3:0] REG_STAT = 4'hF;
	localparam int CTRL_A1_IE = 0;
	localparam int CTRL_A2_IE = 1;
	localparam int CTRL_IRQ_B = 2;
	localparam int CTRL_RATE = 3;
	localparam int STAT_A1F = 0;
	localparam int STAT_A2F = 1;
	localparam int STAT_OSF = 7;
	localparam int HR_MODE12 = 6;
	localparam int HR_PM = 5;
	localparam int ALM_MASK = 7;
	localparam int ALM_DAYSEL = 6;
	localparam int MON_CENT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h18;
	localparam logic [7:0] STAT_RESET = 8'h80;
	localparam logic [7:0] ONE_RESET = 8'h01;
	localparam logic [1:0] RATE_1HZ = 2'h0;
	localparam logic [1:0] RATE_4K = 2'h1;
	localparam logic [1:0] RATE_8K = 2'h2;
	localparam logic [1:0] RATE_32K = 2'h3;
endpackage

// File: verilog/i2c_target.sv
// Two-wire bus target: conditions, address match, byte shifting.
`timescale 1ns/1ps
module i2c_target #(
	parameter logic [6:0] DEV_ADDR = rtc_pkg::ADDR_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [7:0] tx_data,
	output logic sda_oe,
	output logic start_seen,
	output logic stop_seen,
	output logic rx_stb,
	output logic rx_first,
	output logic [7:0] rx_data,
	output logic tx_done
);
	import rtc_pkg::*;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01, S_ADDR = 7'h02, S_ACK_A = 7'h04, S_WRITE = 7'h08,
		S_ACK_W = 7'h10, S_READ = 7'h20, S_ACK_R = 7'h40
	} bus_state_e;
	bus_state_e state, next_state;
	logic [2:0] scl_s, sda_s;
	logic scl_f, sda_f, scl_p, sda_p, next_scl_f, next_sda_f;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shreg, next_shreg, next_rx_data;
	logic rw, next_rw, first, next_first, ack_ok, next_ack_ok;
	logic next_sda_oe, next_rx_stb, next_rx_first, next_tx_done;
	logic scl_rise, scl_fall, cond_start, cond_stop;

	// **********************************************************
	// Pin sampling
	// **********************************************************
	// A level is taken once the second and third stages agree.
	always_comb begin
		next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
		next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
	end

	// Sampling is fast enough for both bus speeds at this clock.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
			scl_f <= next_scl_f;
			sda_f <= next_sda_f;
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	// Edges of the clock line and the bus conditions.
	assign scl_rise = scl_f & ~scl_p;
	assign scl_fall = ~scl_f & scl_p;
	assign cond_start = scl_f & scl_p & sda_p & ~sda_f;
	assign cond_stop = scl_f & scl_p & ~sda_p & sda_f;

	// **********************************************************
	// Transfer sequencer
	// **********************************************************
	// Only reacts to master conditions; bits are sampled on clock rises and driven on clock falls.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shreg = shreg;
		next_rw = rw;
		next_first = first;
		next_ack_ok = ack_ok;
		next_sda_oe = sda_oe;
		next_rx_data = rx_data;
		next_rx_stb = 1'b0;
		next_rx_first = 1'b0;
		next_tx_done = 1'b0;
		if (cond_start) begin
			next_state = S_ADDR;
			next_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (cond_stop) begin
			next_state = S_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			unique case (state)
			S_IDLE: begin
			end
			S_ADDR: begin
				if (scl_rise) begin
					next_shreg = {shreg[6:0], sda_f};
					next_cnt = cnt + 4'h1;
				end else if (scl_fall && cnt == 4'h8) begin
					if (shreg[7:1] == DEV_ADDR) begin
						next_sda_oe = 1'b1;
						next_rw = shreg[0];
						next_state = S_ACK_A;
					end else begin
						next_state = S_IDLE;
					end
				end
			end
			S_ACK_A: begin
				if (scl_fall) begin
					next_cnt = 4'h0;
					if (rw) begin
						next_sda_oe = ~tx_data[7];
						next_shreg = {tx_data[6:0], 1'b0};
						next_cnt = 4'h1;
						next_state = S_READ;
					end else begin
						next_sda_oe = 1'b0;
						next_first = 1'b1;
						next_state = S_WRITE;
					end
				end
			end
			S_WRITE: begin
				if (scl_rise) begin
					next_shreg = {shreg[6:0], sda_f};
					next_cnt = cnt + 4'h1;
				end else if (scl_fall && cnt == 4'h8) begin
					next_sda_oe = 1'b1;
					next_rx_stb = 1'b1;
					next_rx_data = shreg;
					next_rx_first = first;
					next_first = 1'b0;
					next_state = S_ACK_W;
				end
			end
			S_ACK_W: begin
				if (scl_fall) begin
					next_sda_oe = 1'b0;
					next_cnt = 4'h0;
					next_state = S_WRITE;
				end
			end
			S_READ: begin
				if (scl_fall) begin
					if (cnt == 4'h8) begin
						next_sda_oe = 1'b0;
						next_tx_done = 1'b1;
						next_state = S_ACK_R;
					end else begin
						next_sda_oe = ~shreg[7];
						next_shreg = {shreg[6:0], 1'b0};
						next_cnt = cnt + 4'h1;
					end
				end
			end
			S_ACK_R: begin
				if (scl_rise) begin
					next_ack_ok = ~sda_f;
				end else if (scl_fall) begin
					if (ack_ok) begin
						next_sda_oe = ~tx_data[7];
						next_shreg = {tx_data[6:0], 1'b0};
						next_cnt = 4'h1;
						next_state = S_READ;
					end else begin
						next_state = S_IDLE;
					end
				end
			end
			default: next_state = S_IDLE;
			endcase
		end
	end

	// Registers of the sequencer and its strobes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			rw <= 1'b0;
			first <= 1'b0;
			ack_ok <= 1'b0;
			sda_oe <= 1'b0;
			rx_data <= 8'h00;
			rx_stb <= 1'b0;
			rx_first <= 1'b0;
			tx_done <= 1'b0;
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			shreg <= next_shreg;
			rw <= next_rw;
			first <= next_first;
			ack_ok <= next_ack_ok;
			sda_oe <= next_sda_oe;
			rx_data <= next_rx_data;
			rx_stb <= next_rx_stb;
			rx_first <= next_rx_first;
			tx_done <= next_tx_done;
			start_seen <= cond_start;
			stop_seen <= cond_stop;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// The data line is driven only in acknowledge or read phases.
	property p_target_only;
		sda_oe |-> (state inside {S_ACK_A, S_ACK_W, S_READ});
	endproperty
	a_target_only: assert property (p_target_only)
		else $error("Data line driven outside a target phase.");
endmodule

// File: verilog/i2c_calendar_clock_alarms.sv
// Calendar clock with two alarms, square wave and a bus target port.
`timescale 1ns/1ps
module i2c_calendar_clock_alarms #(
	parameter logic [6:0] DEV_ADDR = rtc_pkg::ADDR_DEFAULT,
	parameter int TICK_BITS = rtc_pkg::PRESC_BITS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic crystal_in,
	output logic crystal_out,
	output logic alarm_irq_a_n_out,
	output logic alarm_irq_a_n_oe,
	output logic square_wave_or_irq_b_out,
	output logic square_wave_or_irq_b_oe
);
	import rtc_pkg::*;
	logic [1:0] rst_ff;
	logic rst_n_sync;
	logic [2:0] xs;
	logic xf, xp, next_xf, x_rise, tick, chk;
	logic [TICK_BITS-1:0] presc, next_presc;
	logic [12:0] stop_cnt, next_stop_cnt;
	logic osc_dead;
	logic [7:0] regs [16];
	logic [7:0] next_regs [16];
	logic [7:0] shadow [7];
	logic [7:0] next_shadow [7];
	logic [3:0] ptr, next_ptr;
	logic [7:0] tx_data, rx_data;
	logic start_seen, stop_seen, rx_stb, rx_first, tx_done;
	logic advance, snap, a1_hit, a2_hit, sqw;
	logic next_irq_a, next_irq_b;

	// **********************************************************
	// Helper functions
	// **********************************************************
	// Adds one to a packed decimal value, wrapping at top to low.
	function automatic logic [7:0] bcd_wrap(input logic [7:0] v,
		input logic [7:0] top, input logic [7:0] low);
		if (v == top)
			return low;
		else if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return v + 8'h01;
	endfunction

	// Year is leap when divisible by four, except year 2100.
	function automatic logic leap(input logic [7:0] y, input logic c);
		logic q;
		q = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		return q && !(y == 8'h00 && c);
	endfunction

	// Last date of a month, corrected for short months.
	function automatic logic [7:0] last_date(input logic [7:0] m,
		input logic [7:0] y);
		case (m[4:0])
		5'h02: return leap(y, m[MON_CENT]) ? 8'h29 : 8'h28;
		5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
		default: return 8'h31;
		endcase
	endfunction

	// Next hour in the selected 12 or 24 hour format.
	function automatic logic [7:0] hour_inc(input logic [7:0] h);
		logic [7:0] t;
		if (h[HR_MODE12]) begin
			t = bcd_wrap({3'h0, h[4:0]}, 8'h12, 8'h01);
			if (h[4:0] == 5'h11)
				return {h[7:6], ~h[HR_PM], t[4:0]};
			return {h[7:5], t[4:0]};
		end
		t = bcd_wrap({2'h0, h[5:0]}, 8'h23, 8'h00);
		return {h[7:6], t[5:0]};
	endfunction

	// True when the hour rolls over into a new day.
	function automatic logic hour_carry(input logic [7:0] h);
		if (h[HR_MODE12])
			return h[HR_PM] && h[4:0] == 5'h11;
		return h[5:0] == 6'h23;
	endfunction

	// One alarm field matches when masked or equal.
	function automatic logic fld(input logic [7:0] a, input logic [7:0] t);
		return a[ALM_MASK] || a[6:0] == t[6:0];
	endfunction

	// Day-or-date alarm field, selected by its own bit.
	function automatic logic dd(input logic [7:0] a, input logic [7:0] dy,
		input logic [7:0] dt);
		if (a[ALM_MASK])
			return 1'b1;
		if (a[ALM_DAYSEL])
			return a[3:0] == dy[3:0];
		return a[5:0] == dt[5:0];
	endfunction

	// **********************************************************
	// Reset release and time base
	// **********************************************************
	// Reset asserts at once and releases through two stages.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rst_ff <= 2'h0;
		else
			rst_ff <= {rst_ff[0], 1'b1};
	end
	assign rst_n_sync = rst_ff[1];

	// Crystal or external clock is sampled and filtered.
	always_comb begin
		next_xf = (xs[1] == xs[2]) ? xs[2] : xf;
		next_presc = x_rise ? presc + 1'b1 : presc;
		if (xf != xp)
			next_stop_cnt = 13'h0;
		else if (!osc_dead)
			next_stop_cnt = stop_cnt + 13'h1;
		else
			next_stop_cnt = stop_cnt;
	end
	assign x_rise = xf & ~xp;
	assign tick = x_rise && presc == {TICK_BITS{1'b1}};
	assign osc_dead = stop_cnt == 13'(OSC_STOP_CYCLES);

	// Time base registers; the output pin models the inverting amplifier.
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			xs <= 3'h0;
			xf <= 1'b0;
			xp <= 1'b0;
			presc <= '0;
			stop_cnt <= 13'h0;
			chk <= 1'b0;
			crystal_out <= 1'b1;
		end else begin
			xs <= {xs[1:0], crystal_in};
			xf <= next_xf;
			xp <= xf;
			presc <= next_presc;
			stop_cnt <= next_stop_cnt;
			chk <= tick;
			crystal_out <= ~xf;
		end
	end

	// **********************************************************
	// Bus target
	// **********************************************************
	i2c_target #(.DEV_ADDR(DEV_ADDR)) u_target (
		.clk(clk),
		.rst_n(rst_n_sync),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.tx_data(tx_data),
		.sda_oe(sda_oe),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.rx_stb(rx_stb),
		.rx_first(rx_first),
		.rx_data(rx_data),
		.tx_done(tx_done)
	);
	assign sda_out = 1'b0;

	// Time bytes are read from the shadow, others live.
	assign tx_data = (ptr < REG_A1_SEC) ? shadow[ptr[2:0]] : regs[ptr];
	assign advance = (rx_stb && !rx_first) || tx_done;
	assign snap = start_seen || stop_seen || (advance && ptr == REG_STAT);

	// Alarm comparisons against the running clock.
	assign a1_hit = chk && fld(regs[REG_A1_SEC], regs[REG_SEC]) &&
		fld(regs[REG_A1_MIN], regs[REG_MIN]) &&
		fld(regs[REG_A1_HOUR], regs[REG_HOUR]) &&
		dd(regs[REG_A1_DAY], regs[REG_DAY], regs[REG_DATE]);
	assign a2_hit = chk && regs[REG_SEC] == 8'h00 &&
		fld(regs[REG_A2_MIN], regs[REG_MIN]) &&
		fld(regs[REG_A2_HOUR], regs[REG_HOUR]) &&
		dd(regs[REG_A2_DAY], regs[REG_DAY], regs[REG_DATE]);

	// **********************************************************
	// Register file and calendar
	// **********************************************************
	// Counting, bus writes, pointer and flags; a flag set beats a clear.
	always_comb begin
		next_regs = regs;
		next_shadow = shadow;
		next_ptr = ptr;
		if (tick) begin
			next_regs[REG_SEC] = bcd_wrap(regs[REG_SEC], 8'h59, 8'h00);
			if (regs[REG_SEC] == 8'h59) begin
				next_regs[REG_MIN] = bcd_wrap(regs[REG_MIN], 8'h59, 8'h00);
				if (regs[REG_MIN] == 8'h59) begin
					next_regs[REG_HOUR] = hour_inc(regs[REG_HOUR]);
					if (hour_carry(regs[REG_HOUR])) begin
						next_regs[REG_DAY] =
							bcd_wrap(regs[REG_DAY], 8'h07, 8'h01);
						next_regs[REG_DATE] = bcd_wrap(regs[REG_DATE],
							last_date(regs[REG_MON], regs[REG_YEAR]),
							8'h01);
						if (regs[REG_DATE] ==
							last_date(regs[REG_MON], regs[REG_YEAR])) begin
							next_regs[REG_MON] = bcd_wrap(
								{1'b0, regs[REG_MON][6:0]}, 8'h12, 8'h01);
							next_regs[REG_MON][MON_CENT] =
								regs[REG_MON][MON_CENT];
							if (regs[REG_MON][6:0] == 7'h12) begin
								next_regs[REG_YEAR] = bcd_wrap(
									regs[REG_YEAR], 8'h99, 8'h00);
								if (regs[REG_YEAR] == 8'h99)
									next_regs[REG_MON][MON_CENT] =
										~regs[REG_MON][MON_CENT];
							end
						end
					end
				end
			end
		end
		if (rx_stb && rx_first) begin
			next_ptr = rx_data[3:0];
		end else if (rx_stb) begin
			if (ptr == REG_STAT)
				next_regs[REG_STAT] = regs[REG_STAT] & rx_data &
					8'h83;
			else
				next_regs[ptr] = rx_data;
		end
		if (advance)
			next_ptr = ptr + 4'h1;
		if (a1_hit)
			next_regs[REG_STAT][STAT_A1F] = 1'b1;
		if (a2_hit)
			next_regs[REG_STAT][STAT_A2F] = 1'b1;
		if (osc_dead)
			next_regs[REG_STAT][STAT_OSF] = 1'b1;
		if (snap) begin
			for (int i = 0; i < 7; i++)
				next_shadow[i] = regs[i];
		end
	end

	// Register file storage with power-up calendar values.
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			for (int i = 0; i < 16; i++)
				regs[i] <= 8'h00;
			regs[REG_DAY] <= ONE_RESET;
			regs[REG_DATE] <= ONE_RESET;
			regs[REG_MON] <= ONE_RESET;
			regs[REG_CTRL] <= CTRL_RESET;
			regs[REG_STAT] <= STAT_RESET;
			for (int i = 0; i < 7; i++)
				shadow[i] <= 8'h00;
			ptr <= 4'h0;
		end else begin
			regs <= next_regs;
			shadow <= next_shadow;
			ptr <= next_ptr;
		end
	end

	// **********************************************************
	// Interrupt and square-wave pins
	// **********************************************************
	// Rate select picks a prescaler tap or the time base itself.
	always_comb begin
		unique case (regs[REG_CTRL][CTRL_RATE +: 2])
		RATE_1HZ: sqw = presc[TICK_BITS-1];
		RATE_4K: sqw = presc[2];
		RATE_8K: sqw = presc[1];
		RATE_32K: sqw = xf;
		endcase
		next_irq_a = (regs[REG_STAT][STAT_A1F] &&
			regs[REG_CTRL][CTRL_A1_IE]) ||
			(regs[REG_STAT][STAT_A2F] && regs[REG_CTRL][CTRL_A2_IE] &&
			!regs[REG_CTRL][CTRL_IRQ_B]);
		if (regs[REG_CTRL][CTRL_IRQ_B])
			next_irq_b = regs[REG_STAT][STAT_A2F] &&
				regs[REG_CTRL][CTRL_A2_IE];
		else
			next_irq_b = ~sqw;
	end

	// Open-drain pins are pulled low while their enable is high.
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			alarm_irq_a_n_oe <= 1'b0;
			square_wave_or_irq_b_oe <= 1'b0;
		end else begin
			alarm_irq_a_n_oe <= next_irq_a;
			square_wave_or_irq_b_oe <= next_irq_b;
		end
	end
	assign alarm_irq_a_n_out = 1'b0;
	assign square_wave_or_irq_b_out = 1'b0;

	// **********************************************************
	// Checks
	// **********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_sync);

	property p_irq_a;
		regs[REG_STAT][STAT_A1F] && regs[REG_CTRL][CTRL_A1_IE]
			|=> alarm_irq_a_n_oe;
	endproperty
	a_irq_a: assert property (p_irq_a)
		else $error("Alarm one pending but interrupt pin released.");

	property p_ptr_step;
		rx_stb && !rx_first && !tx_done |=> ptr == $past(ptr) + 4'h1;
	endproperty
	a_ptr_step: assert property (p_ptr_step)
		else $error("Pointer did not advance after a data byte.");

	property p_ptr_wrap;
		tx_done && ptr == REG_STAT |=> ptr == REG_SEC;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap)
		else $error("Pointer did not wrap to zero.");

	property p_snap;
		start_seen |=> shadow[0] == $past(regs[0]) &&
			shadow[6] == $past(regs[6]);
	endproperty
	a_snap: assert property (p_snap)
		else $error("Shadow not loaded at START.");

	property p_month_end;
		tick && !rx_stb && regs[REG_SEC] == 8'h59 &&
			regs[REG_MIN] == 8'h59 && hour_carry(regs[REG_HOUR]) &&
			regs[REG_DATE] == last_date(regs[REG_MON], regs[REG_YEAR])
			|=> regs[REG_DATE] == 8'h01;
	endproperty
	a_month_end: assert property (p_month_end)
		else $error("Date did not roll over at month end.");

	property p_rate_reset;
		$rose(rst_n_sync) |-> regs[REG_CTRL][CTRL_RATE +: 2] == RATE_32K;
	endproperty
	a_rate_reset: assert property (p_rate_reset)
		else $error("Square wave rate not 32 kHz after reset.");

	property p_flag_hold;
		regs[REG_STAT][STAT_A1F] && !(rx_stb && !rx_first &&
			ptr == REG_STAT) |=> regs[REG_STAT][STAT_A1F];
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("Alarm flag dropped without a software clear.");

	property p_osc_stop;
		stop_cnt == 13'(OSC_STOP_CYCLES - 1) && xf == xp && xs[2] == xf
			|=> ##1 regs[REG_STAT][STAT_OSF];
	endproperty
	a_osc_stop: assert property (p_osc_stop)
		else $error("Oscillator stop not flagged.");

	property p_hour24;
		tick && !rx_stb && !regs[REG_HOUR][HR_MODE12] &&
			regs[REG_HOUR][5:0] == 6'h23 && regs[REG_MIN] == 8'h59 &&
			regs[REG_SEC] == 8'h59 |=> regs[REG_HOUR][5:0] == 6'h00;
	endproperty
	a_hour24: assert property (p_hour24)
		else $error("Hour did not wrap at midnight.");
endmodule

// File: sim/bus_master.sv
// Behavioural two-wire bus master that drives the calendar clock port.
`timescale 1ns/1ps
module bus_master (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic drv = 1'b1;
	int hp = 200;
	// The data line is pulled up; either party may pull it low.
	assign sda = drv & ~sda_oe;
	initial scl = 1'b1;
	// Steps to just after a rising clock edge, n times.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Data falls while the bus clock is high; repeated use is allowed.
	task automatic start();
		drv = 1'b1;
		tick(hp / 4);
		scl = 1'b1;
		tick(hp / 2);
		drv = 1'b0;
		tick(hp / 2);
		scl = 1'b0;
		tick(hp / 4);
	endtask
	// Data rises while the bus clock is high, ending the transfer.
	task automatic stop();
		drv = 1'b0;
		tick(hp / 4);
		scl = 1'b1;
		tick(hp / 2);
		drv = 1'b1;
		tick(hp / 2);
	endtask
	// One bit: data set in the low phase, line sampled mid high phase.
	task automatic bitx(input logic b, output logic r);
		drv = b;
		tick(hp / 4);
		scl = 1'b1;
		tick(hp / 2);
		r = sda;
		tick(hp / 2);
		scl = 1'b0;
		tick(hp / 4);
	endtask
	// A byte MSB first, then the acknowledge bit; an 8'hFF byte reads.
	task automatic xfer(input logic [7:0] d, input logic a_in,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(a_in, a);
	endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the calendar clock and its bus port.
`timescale 1ns/1ps
module testbench;
	import rtc_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic crystal_in = 1'b0;
	logic run = 1'b1;
	logic scl, sda, sda_oe, sqw_oe, irq_a_oe, xo;
	// A short prescaler lets seconds pass within the run.
	localparam int TICK_BITS = 5;
	logic [7:0] q;
	logic ack;
	int fail_count = 0;
	int check_count = 0;
	int c;
	int rise_exp[4] = '{1, 4, 8, 32};
	// The system clock, and a 200 ns time base in an unrelated phase.
	always #12.5 clk = ~clk;
	initial begin
		#3;
		forever #100 if (run) crystal_in = ~crystal_in;
	end
	i2c_calendar_clock_alarms #(.TICK_BITS(TICK_BITS)) u_dut (.clk(clk),
		.reset_n(reset_n),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.crystal_in(crystal_in), .crystal_out(xo),
		.alarm_irq_a_n_out(), .alarm_irq_a_n_oe(irq_a_oe),
		.square_wave_or_irq_b_out(), .square_wave_or_irq_b_oe(sqw_oe));
	bus_master u_master (.clk(clk), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));
	task automatic check_byte(input string n, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic check_bit(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
			fail_count++;
		end
	endtask
	// Writes bytes from pointer p in one transfer, each one acknowledged.
	task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
		u_master.start();
		u_master.xfer({ADDR_DEFAULT, 1'b0}, 1'b1, q, ack);
		check_bit("write ack", 1'b0, ack);
		u_master.xfer(p, 1'b1, q, ack);
		foreach (d[i]) begin
			u_master.xfer(d[i], 1'b1, q, ack);
			check_bit("data ack", 1'b0, ack);
		end
		u_master.stop();
	endtask
	// Sets the pointer, then reads with a repeated start; last byte NACKed.
	task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
		u_master.start();
		u_master.xfer({ADDR_DEFAULT, 1'b0}, 1'b1, q, ack);
		u_master.xfer(p, 1'b1, q, ack);
		u_master.start();
		u_master.xfer({ADDR_DEFAULT, 1'b1}, 1'b1, q, ack);
		check_bit("read ack", 1'b0, ack);
		foreach (e[i]) begin
			u_master.xfer(8'hFF, i == e.size() - 1, q, ack);
			check_byte("read data", e[i], q);
		end
		u_master.stop();
	endtask
	// Counts rising edges of the second pin's enable over n clocks.
	task automatic count_rises(input int n);
		logic prev;
		c = 0;
		prev = sqw_oe;
		repeat (n) begin
			u_master.tick(1);
			if (sqw_oe && !prev) c++;
			prev = sqw_oe;
		end
	endtask
	task automatic results();
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		u_master.tick(8);
		reset_n = 1'b1;
		u_master.tick(8);
		rd(REG_CTRL, '{CTRL_RESET, STAT_RESET});
		count_rises(256);
		check_bit("wave at reset", 1'b1, c >= 31 && c <= 33);
		u_master.hp = 50;
		for (int r = 3; r >= 0; r--) begin
			wr(REG_CTRL, '{{3'h0, 2'(r), 3'h0}});
			count_rises(256);
			check_bit("wave rate", 1'b1, (c >= rise_exp[r] - 1) &&
				(c <= rise_exp[r] + 1));
		end
		wr(REG_CTRL, '{8'h06});
		count_rises(256);
		check_bit("pin b as irq", 1'b1, c == 0 && sqw_oe === 1'b0);
		check_bit("irq a idle", 1'b0, irq_a_oe);
		wr(REG_A1_SEC, '{8'h11, 8'h22, 8'h12, 8'h05, 8'h33, 8'h08,
			8'h06});
		rd(REG_A1_SEC, '{8'h11, 8'h22, 8'h12, 8'h05, 8'h33, 8'h08,
			8'h06});
		// Time stands still while the crystal is held, so reads are exact.
		run = 1'b0;
		wr(REG_SEC, '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02,
			8'h01});
		rd(REG_CTRL, '{8'h06, STAT_RESET, 8'h59});
		// One or two seconds pass: end of February in a common year.
		run = 1'b1;
		u_master.tick(300);
		run = 1'b0;
		rd(REG_MIN, '{8'h00, 8'h00, 8'h01, 8'h01, 8'h03,
			8'h01});
		wr(REG_HOUR, '{8'h52});
		rd(REG_HOUR, '{8'h52});
		// Alarm one matches at the next second; alarm two does not.
		wr(REG_SEC, '{8'h10, 8'h22, 8'h12, 8'h03, 8'h05});
		wr(REG_CTRL, '{8'h07});
		run = 1'b1;
		u_master.tick(300);
		run = 1'b0;
		check_bit("alarm a pin", 1'b1, irq_a_oe);
		check_bit("alarm b pin", 1'b0, sqw_oe);
		rd(REG_STAT, '{8'h81});
		wr(REG_STAT, '{8'h00});
		check_bit("alarm a cleared", 1'b0, irq_a_oe);
		run = 1'b1;
		wr(REG_STAT, '{8'h00});
		rd(REG_STAT, '{8'h00});
		run = 1'b0;
		u_master.tick(4100);
		check_bit("crystal out", ~crystal_in, xo);
		run = 1'b1;
		rd(REG_STAT, '{STAT_RESET});
		u_master.start();
		u_master.xfer({ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1, q, ack);
		check_bit("foreign address", 1'b1, ack);
		u_master.stop();
		results();
	end
	// Cuts a hung run short through the same closing task.
	initial begin
		#2500000;
		fail_count++;
		results();
	end
endmodule
